// ---- logic/ddr2_spacing_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
module ddr2_spacing_ctrl
    import ddr2_spacing_pkg::*;
#(
    parameter bit       WIDE_PART   = 1'b0,
    parameter bit       FAST_GRADE  = 1'b1,
    parameter int       AL          = 0,
    parameter int       BURST_LEN   = 4,
    parameter int       WR_CYC      = 3,
    parameter int       RP_CYC      = 3
) (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        req_valid,
    input  wire logic [3:0]  req_cmd,
    input  wire logic [15:0] req_addr,
    input  wire logic        req_odt,
    output logic             req_ready,
    output logic             cmd_valid,
    output logic [3:0]       cmd,
    output logic [15:0]      cmd_addr,
    output logic             cke,
    output logic             odt,
    output logic             odt_reliable,
    output logic             strobe_diff,
    output logic             slow_exit
);
    typedef struct packed {
        logic        ready;
        logic        valid;
        logic [3:0]  cmd;
        logic [15:0] addr;
        logic        cke;
        logic        odt;
        logic        odt_ok;
        logic        diff;
        logic        slow;
        logic        act_pd;
        logic        in_sref;
        logic        row_open;
    } ctrl_s;

    ctrl_s state;
    ctrl_s next_state;

    // ----------------------------------------------------------------
    // Spacing timers, one per constraint class
    // ----------------------------------------------------------------
    localparam int NT = 10;
    localparam int T_ACT = 0, T_COL = 1, T_RD = 2, T_PRE = 3, T_ANY = 4;
    localparam int T_CKE = 5, T_ODT = 6, T_ODTX = 7, T_WRA = 8, T_SRNR = 9;

    logic [NT-1:0]    ld;
    logic [CNT_W-1:0] val [NT];
    logic [NT-1:0]    ok;

    genvar g;
    generate
        for (g = 0; g < NT; g++) begin : g_tmr
            spacing_timer #(.W(CNT_W)) u_tmr (
                .clk    (clk),
                .arst_n (arst_n),
                .load   (ld[g]),
                .value  (val[g]),
                .done   (ok[g])
            );
        end
    endgenerate

    // Derived cycle counts; the counter reads done one cycle after load
    localparam int ACT_NS_CYC = WIDE_PART ? ACT_ACT_X16_CYC : ACT_ACT_X8_CYC;
    localparam int ACT_CYC    = ACT_NS_CYC < ACT_ACT_MIN_CYC ? ACT_ACT_MIN_CYC : ACT_NS_CYC;
    localparam int RP_MIN     = AL + BURST_LEN / 2;
    // Internal read point sits AL cycles after the read
    localparam int RD_PRE_CYC = RP_MIN > AL + READ_PRE_CYC ? RP_MIN : AL + READ_PRE_CYC;
    localparam int WR_END_CYC = AL + BURST_LEN / 2 + WRITE_READ_CYC;
    localparam int SLOW_BASE  = FAST_GRADE ? SLOW_EXIT_BASE_HI : SLOW_EXIT_BASE_LO;
    localparam int SLOW_CYC   = SLOW_BASE - AL < 1 ? 1 : SLOW_BASE - AL;

    function automatic logic [CNT_W-1:0] cy(input int n);
        cy = CNT_W'(n - 1);
    endfunction

    cmd_e c;
    logic legal;
    logic ready_pulse;

    // ----------------------------------------------------------------
    // Legality of the pending command against all open spacings
    // ----------------------------------------------------------------
    always_comb begin
        c     = cmd_e'(req_cmd);
        legal = ok[T_ANY] && ok[T_CKE];
        unique case (c)
            CMD_ACT: legal = legal && ok[T_ACT] && ok[T_WRA] && ok[T_SRNR]; // RULE_01 RULE_04
            CMD_RD, CMD_RDA: legal = legal && ok[T_COL] && ok[T_RD];   // RULE_03 RULE_05
            CMD_WR, CMD_WRA: legal = legal && ok[T_COL] && ok[T_SRNR]; // RULE_03
            CMD_PRE: legal = legal && ok[T_PRE] && ok[T_SRNR];         // RULE_06 RULE_07
            CMD_PD_ENTER, CMD_SREF_ENTER: begin
                // A termination change in the entry cycle would void the settle window
                legal = legal && ok[T_ODT] && ok[T_SRNR] && (req_odt == state.odt); // RULE_15
            end
            default: legal = legal && ok[T_SRNR];                      // RULE_09
        endcase
        ready_pulse = !state.valid && legal;
    end

    // ----------------------------------------------------------------
    // Issue and timer loads
    // ----------------------------------------------------------------
    always_comb begin
        next_state       = state;
        next_state.valid = 1'b0;
        next_state.ready = ready_pulse && !req_valid;
        ld               = '0;
        for (int i = 0; i < NT; i++) begin
            val[i] = '0;
        end
        // Termination change restarts its settle window before power-down
        if (req_odt != state.odt) begin
            next_state.odt = req_odt;
            ld[T_ODT]  = 1'b1;                                         // RULE_15
            val[T_ODT] = cy(ODT_PD_ENTRY_CYC);
        end
        if (req_valid && ready_pulse) begin
            next_state.valid = 1'b1;
            next_state.ready = 1'b1;
            next_state.cmd   = req_cmd;
            next_state.addr  = req_addr;
            unique case (c)
                CMD_ACT: begin
                    next_state.row_open = 1'b1;
                    ld[T_ACT]  = 1'b1;                                 // RULE_01 RULE_02
                    val[T_ACT] = cy(ACT_CYC);                          // RULE_19
                end
                CMD_RD, CMD_RDA: begin
                    ld[T_COL]  = 1'b1;                                 // RULE_03
                    val[T_COL] = cy(COL_COL_CYC);
                    ld[T_PRE]  = 1'b1;                                 // RULE_06 RULE_07
                    val[T_PRE] = cy(RD_PRE_CYC);
                end
                CMD_WR, CMD_WRA: begin
                    ld[T_COL]  = 1'b1;
                    val[T_COL] = cy(COL_COL_CYC);
                    ld[T_RD]   = 1'b1;                                 // RULE_05
                    val[T_RD]  = cy(WR_END_CYC);
                    if (c == CMD_WRA) begin
                        ld[T_WRA]  = 1'b1;                             // RULE_04
                        val[T_WRA] = cy(WR_END_CYC - WRITE_READ_CYC + WR_CYC + RP_CYC);
                    end
                end
                CMD_MRS: begin
                    ld[T_ANY]  = 1'b1;                                 // RULE_17
                    val[T_ANY] = cy(MODE_SET_CYC);
                    // Bit twelve of the mode word picks exit speed
                    if (req_addr[15:14] == 2'b00) begin
                        next_state.slow = req_addr[MODE_EXIT_BIT];     // RULE_14
                    end else if (req_addr[15:14] == 2'b01) begin
                        next_state.diff = !req_addr[EMODE_STROBE_BIT]; // RULE_18
                    end
                end
                CMD_PD_ENTER, CMD_SREF_ENTER: begin
                    next_state.cke     = 1'b0;
                    next_state.odt_ok  = 1'b0;
                    // Any row opened since the last refresh counts as active power-down;
                    // no bank tracking, so a plain precharge never clears it (safe side)
                    next_state.act_pd  = state.row_open;
                    next_state.in_sref = (c == CMD_SREF_ENTER);
                    if (c == CMD_SREF_ENTER) begin
                        next_state.row_open = 1'b0;
                    end
                    ld[T_CKE]  = 1'b1;                                 // RULE_08
                    val[T_CKE] = cy(CKE_MIN_CYC);
                end
                CMD_PD_EXIT, CMD_SREF_EXIT: begin
                    next_state.cke = 1'b1;
                    ld[T_CKE]  = 1'b1;                                 // RULE_08
                    val[T_CKE] = cy(CKE_MIN_CYC);
                    ld[T_ODTX]  = 1'b1;                                // RULE_16
                    val[T_ODTX] = cy(ODT_PD_EXIT_CYC);
                    ld[T_ANY]   = 1'b1;                                // RULE_11
                    val[T_ANY]  = cy(PPD_EXIT_CYC);
                    ld[T_RD]    = 1'b1;
                    if (state.in_sref) begin
                        val[T_RD]    = cy(SREF_READ_CYC);              // RULE_10
                        ld[T_SRNR]   = 1'b1;                           // RULE_09
                        val[T_SRNR]  = cy(SREF_NONREAD_CYC);
                    end else if (state.act_pd && state.slow) begin
                        val[T_RD] = cy(SLOW_CYC);                      // RULE_13
                    end else begin
                        val[T_RD] = cy(FAST_EXIT_CYC);                 // RULE_12
                    end
                    next_state.in_sref = 1'b0;
                end
                CMD_REF: begin
                    // Refresh needs every bank idle, so no row is open after it
                    next_state.row_open = 1'b0;
                end
                default: begin
                end
            endcase
        end
        // Next clock enable, so the clear at power-down entry is not undone
        if (next_state.cke && ok[T_ODTX] && !ld[T_ODTX]) begin
            next_state.odt_ok = 1'b1;                                  // RULE_16
        end
    end

    // State register; reset leaves clock enable high and termination trusted
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= '{cke: 1'b1, odt_ok: 1'b1, diff: 1'b1, default: '0};
        end else begin
            state <= next_state;
        end
    end

    // Outputs straight from the state flops
    assign req_ready    = state.ready;
    assign cmd_valid    = state.valid;
    assign cmd          = state.cmd;
    assign cmd_addr     = state.addr;
    assign cke          = state.cke;
    assign odt          = state.odt;
    assign odt_reliable = state.odt_ok;
    assign strobe_diff  = state.diff;
    assign slow_exit    = state.slow;
endmodule : ddr2_spacing_ctrl
`default_nettype wire

// ---- logic/ddr2_spacing_pkg.sv ----
// Functional notes
// RULE_01 - Activates to different banks spaced 7.5 ns (by-eight) or 10 ns (by-sixteen).
// RULE_02 - Activate-to-activate spacing never below two clock cycles.
// RULE_03 - Read or write commands at least 2 cycles apart.
// RULE_04 - After write with auto-precharge, wait write recovery plus precharge cycles.
// RULE_05 - Read after write waits 7.5 ns from internal write end.
// RULE_06 - Precharge after read waits 7.5 ns from internal read point.
// RULE_07 - Read to precharge at least additive latency plus half burst length.
// RULE_08 - Clock enable held at each level at least 3 cycles.
// RULE_09 - Self refresh exit to non-read command waits refresh time plus 10 ns.
// RULE_10 - Self refresh exit to read waits 200 cycles; a write or power-down exit in between cuts the read wait short.
// RULE_11 - Precharge power-down exit waits 2 cycles before any command.
// RULE_12 - Fast active power-down exit allows read after 2 cycles.
// RULE_13 - Slow active power-down exit read waits 7 or 8 minus additive latency; a write in between reloads the read timer with the write-to-read wait.
// RULE_14 - Mode bit twelve picks fast or slow exit; controller applies matching delay.
// RULE_15 - Termination control settled 3 cycles before power-down entry.
// RULE_16 - After power-down exit, 8 cycles before relying on termination control.
// RULE_17 - Any command after mode register set waits 2 cycles.
// RULE_18 - Strobe single-ended or differential per extended mode strobe-enable bit.
// RULE_19 - Nanosecond spacings become whole cycles, rounded up at clock period.
package ddr2_spacing_pkg;

    // ----------------------------------------------------------------
    // Clock and timing figures
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_PS     = 5000;
    localparam int ACT_ACT_X8_PS     = 7500;
    localparam int ACT_ACT_X16_PS    = 10000;
    localparam int WRITE_READ_PS     = 7500;
    localparam int READ_PRE_PS       = 7500;
    localparam int SREF_EXTRA_PS     = 10000;
    localparam int REFRESH_CYCLE_PS  = 105000;

    // Rounded up to whole cycles
    localparam int ACT_ACT_X8_CYC   = (ACT_ACT_X8_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int ACT_ACT_X16_CYC  = (ACT_ACT_X16_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WRITE_READ_CYC   = (WRITE_READ_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int READ_PRE_CYC     = (READ_PRE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SREF_NONREAD_CYC =
        (REFRESH_CYCLE_PS + SREF_EXTRA_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    localparam int ACT_ACT_MIN_CYC   = 2;
    localparam int COL_COL_CYC       = 2;
    localparam int CKE_MIN_CYC       = 3;
    localparam int SREF_READ_CYC     = 200;
    localparam int PPD_EXIT_CYC      = 2;
    localparam int FAST_EXIT_CYC     = 2;
    localparam int SLOW_EXIT_BASE_LO = 7;
    localparam int SLOW_EXIT_BASE_HI = 8;
    localparam int ODT_PD_ENTRY_CYC  = 3;
    localparam int ODT_PD_EXIT_CYC   = 8;
    localparam int MODE_SET_CYC      = 2;

    localparam int CNT_W = 8;

    // ----------------------------------------------------------------
    // Commands
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_WRA, CMD_RDA, CMD_PRE,
        CMD_REF, CMD_MRS, CMD_SREF_ENTER, CMD_SREF_EXIT, CMD_PD_ENTER,
        CMD_PD_EXIT
    } cmd_e;

    localparam int MODE_EXIT_BIT   = 12;
    localparam int EMODE_STROBE_BIT = 10;

endpackage : ddr2_spacing_pkg

// ---- logic/spacing_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module spacing_timer
    import ddr2_spacing_pkg::*;
#(
    parameter int W = CNT_W
) (
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic         load,
    input  wire logic [W-1:0] value,
    output logic              done
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } timer_s;

    timer_s state;
    timer_s next_state;

    // ----------------------------------------------------------------
    // Down counter; a load of n keeps done low n cycles
    // ----------------------------------------------------------------
    always_comb begin
        next_state = state;
        if (load) begin
            next_state.cnt = value;
        end else if (state.cnt != '0) begin
            next_state.cnt = state.cnt - W'(1);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign done = (state.cnt == '0);
endmodule : spacing_timer
`default_nettype wire

// ---- test/ddr2_device_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Memory device: mode decode, early commands
// ----------------------------------------
module ddr2_device_model
    import ddr2_spacing_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        cmd_valid,
    input  wire logic [3:0]  cmd,
    input  wire logic [15:0] cmd_addr,
    output logic             dev_strobe_diff,
    output logic             dev_slow_exit,
    output logic [7:0]       dev_errs
);
    int now, last_act, last_mrs;
    // Early commands are counted, not refused, so the bench sees every one
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dev_strobe_diff <= 1'b1;
            dev_slow_exit   <= 1'b0;
            dev_errs        <= 8'h00;
            now             <= 0;
            last_act        <= -100;
            last_mrs        <= -100;
        end else begin
            now <= now + 1;
            if (cmd_valid) begin
                if ((cmd == CMD_ACT && now - last_act < ACT_ACT_MIN_CYC)
                    || now - last_mrs < MODE_SET_CYC) dev_errs <= dev_errs + 8'h01;
                if (cmd == CMD_ACT) last_act <= now;
                if (cmd == CMD_MRS) begin
                    last_mrs <= now;
                    if (cmd_addr[15:14] == 2'b00) dev_slow_exit <= cmd_addr[MODE_EXIT_BIT];
                    if (cmd_addr[15:14] == 2'b01) dev_strobe_diff <= !cmd_addr[EMODE_STROBE_BIT];
                end
            end
        end
    end
endmodule : ddr2_device_model
`default_nettype wire

// ---- test/ddr2_spacing_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Spacing checks on the issued stream
// ----------------------------------------
module ddr2_spacing_checker
    import ddr2_spacing_pkg::*;
(
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic        req_valid,
    input wire logic [3:0]  req_cmd,
    input wire logic [15:0] req_addr,
    input wire logic        req_odt,
    input wire logic        req_ready,
    input wire logic        cmd_valid,
    input wire logic [3:0]  cmd,
    input wire logic [15:0] cmd_addr,
    input wire logic        cke,
    input wire logic        odt,
    input wire logic        odt_reliable,
    input wire logic        strobe_diff,
    input wire logic        slow_exit
);
    logic [7:0] since_sref;
    // Saturating count so that an old exit never trips a check
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) since_sref <= 8'hFF;
        else if (cmd_valid && cmd == CMD_SREF_EXIT) since_sref <= 8'h00;
        else if (since_sref != 8'hFF) since_sref <= since_sref + 8'h01;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_act_act_gap: assert property (cmd_valid && cmd == CMD_ACT
        |=> !(cmd_valid && cmd == CMD_ACT)) else $error("activates too close");
    a_col_col_gap: assert property (cmd_valid && cmd inside {CMD_RD, CMD_WR, CMD_WRA, CMD_RDA}
        |=> !cmd_valid) else $error("column commands too close");
    a_wra_act_wait: assert property (cmd_valid && cmd == CMD_WRA
        |=> !(cmd_valid && cmd == CMD_ACT)[*5]) else $error("activate too soon after WRA");
    a_wr_rd_wait: assert property (cmd_valid && cmd inside {CMD_WR, CMD_WRA}
        |=> !(cmd_valid && cmd inside {CMD_RD, CMD_RDA})[*3]) else $error("read too soon");
    a_cke_pulse: assert property ($changed(cke) |=> $stable(cke)[*2])
        else $error("clock enable pulse too short");
    a_sref_read_wait: assert property (cmd_valid && cmd inside {CMD_RD, CMD_RDA}
        |-> int'(since_sref) >= SREF_READ_CYC - 1) else $error("read too soon after exit");
    a_sref_other_wait: assert property (cmd_valid && !(cmd inside {CMD_RD, CMD_RDA,
        CMD_NOP, CMD_SREF_EXIT}) |-> int'(since_sref) >= SREF_NONREAD_CYC - 1)
        else $error("command too soon after exit");
    a_pd_exit_gap: assert property (cmd_valid && cmd == CMD_PD_EXIT |=> !cmd_valid)
        else $error("command too soon after power-down exit");
    a_odt_settle: assert property (cmd_valid && cmd == CMD_PD_ENTER
        |-> odt == $past(odt) && odt == $past(odt, 2) && odt == $past(odt, 3))
        else $error("termination not settled at entry");
    a_odt_reliable: assert property (cmd_valid && cmd == CMD_PD_EXIT
        |-> !odt_reliable[*7] ##[1:3] odt_reliable) else $error("termination flag timing");
    a_mrs_gap: assert property (cmd_valid && cmd == CMD_MRS |=> !cmd_valid)
        else $error("command too soon after mode set");
    a_strobe_mode: assert property (cmd_valid && cmd == CMD_MRS && cmd_addr[15:14] == 2'b01
        |-> ##[0:1] strobe_diff == !cmd_addr[EMODE_STROBE_BIT]) else $error("strobe mode");
    a_exit_mode: assert property (cmd_valid && cmd == CMD_MRS && cmd_addr[15:14] == 2'b00
        |-> ##[0:1] slow_exit == cmd_addr[MODE_EXIT_BIT]) else $error("exit mode");
endmodule : ddr2_spacing_checker
bind ddr2_spacing_ctrl ddr2_spacing_checker ddr2_spacing_checker_inst (.clk(clk),
    .arst_n(arst_n), .req_valid(req_valid), .req_cmd(req_cmd), .req_addr(req_addr),
    .req_odt(req_odt), .req_ready(req_ready), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_addr(cmd_addr), .cke(cke), .odt(odt), .odt_reliable(odt_reliable),
    .strobe_diff(strobe_diff), .slow_exit(slow_exit));
`default_nettype wire

// ---- test/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Command spacing bench
// ----------------------------------------
module tb;
    import ddr2_spacing_pkg::*;
    logic        clk, arst_n, req_valid, req_odt, req_ready, cmd_valid, cke, odt;
    logic        odt_reliable, strobe_diff, slow_exit, dev_strobe_diff, dev_slow_exit;
    logic [3:0]  req_cmd, cmd;
    logic [15:0] req_addr, cmd_addr;
    logic [7:0]  dev_errs;
    int          cyc, fails, checks_done;
    ddr2_spacing_ctrl #(.WIDE_PART(1'b0), .FAST_GRADE(1'b1), .BURST_LEN(4),
        .WR_CYC(3), .RP_CYC(3)) ddr2_spacing_ctrl_inst (.clk(clk), .arst_n(arst_n),
        .req_valid(req_valid), .req_cmd(req_cmd), .req_addr(req_addr), .req_odt(req_odt),
        .req_ready(req_ready), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_addr(cmd_addr),
        .cke(cke), .odt(odt), .odt_reliable(odt_reliable), .strobe_diff(strobe_diff),
        .slow_exit(slow_exit));
    ddr2_device_model ddr2_device_model_inst (.clk(clk), .arst_n(arst_n), .cmd_valid(cmd_valid),
        .cmd(cmd), .cmd_addr(cmd_addr), .dev_strobe_diff(dev_strobe_diff),
        .dev_slow_exit(dev_slow_exit), .dev_errs(dev_errs));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : tally_and_finish
    // Hold the request until taken; returns the cycle it was issued
    task automatic send(input cmd_e c, input logic [15:0] a, output int at);
        int n;
        @(posedge clk);
        #1 req_cmd = c;
        req_addr  = a;
        req_valid = 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while (req_ready !== 1'b1 && n < 600);
        req_valid = 1'b0;
        at = cyc;
        check(n < 600, 1);
    endtask : send
    task automatic s_act_col;
        int t0, t1, t2, t3;
        send(CMD_ACT, 16'h0000, t0);
        send(CMD_ACT, 16'h4000, t1);
        check(t1 - t0 >= ACT_ACT_X8_CYC && t1 - t0 >= ACT_ACT_MIN_CYC, 1);
        send(CMD_WR, 16'h0010, t2);
        send(CMD_RD, 16'h0010, t3);
        check(t3 - t2 >= 4 / 2 + WRITE_READ_CYC, 1);
        send(CMD_RD, 16'h0020, t0);
        check(t0 - t3 >= COL_COL_CYC, 1);
        send(CMD_PRE, 16'h0000, t1);
        check(t1 - t0 >= 4 / 2 && t1 - t0 >= READ_PRE_CYC, 1);
        send(CMD_WRA, 16'h0400, t2);
        send(CMD_ACT, 16'h0000, t3);
        check(t3 - t2 >= 3 + 3, 1);
    endtask : s_act_col
    task automatic s_modes;
        int t0, t1;
        send(CMD_MRS, 16'h4400, t0);
        send(CMD_MRS, 16'h1000, t1);
        check(t1 - t0 >= MODE_SET_CYC, 1);
        @(posedge clk);
        #1 check(strobe_diff, 0);
        check(slow_exit, 1);
        send(CMD_MRS, 16'h4000, t0);
        send(CMD_MRS, 16'h0000, t1);
        @(posedge clk);
        #1 check({strobe_diff, slow_exit}, 2'b10);
        check({dev_strobe_diff, dev_slow_exit}, 2'b10);
    endtask : s_modes
    task automatic s_power;
        int t0, t1, t2, todt;
        todt = cyc;
        req_odt = 1'b1;
        send(CMD_PD_ENTER, 16'h0000, t0);
        check(t0 - (todt + 1) >= ODT_PD_ENTRY_CYC, 1);
        check({cke, odt_reliable}, 2'b00);
        send(CMD_PD_EXIT, 16'h0000, t1);
        check(t1 - t0 >= CKE_MIN_CYC, 1);
        check({cke, odt_reliable}, 2'b10);
        send(CMD_ACT, 16'h0000, t2);
        check(t2 - t1 >= PPD_EXIT_CYC, 1);
        while (cyc < t1 + ODT_PD_EXIT_CYC + 1) @(posedge clk);
        #1 check(odt_reliable, 1);
        // Slow exit with a row still open holds the read off longest
        send(CMD_MRS, 16'h1000, t0);
        send(CMD_PD_ENTER, 16'h0000, t0);
        send(CMD_PD_EXIT, 16'h0000, t1);
        send(CMD_RD, 16'h0000, t2);
        check(slow_exit, 1);
        check(t2 - t1 >= SLOW_EXIT_BASE_HI, 1);
    endtask : s_power
    task automatic s_sref;
        int t0, t1, t2;
        send(CMD_SREF_ENTER, 16'h0000, t0);
        send(CMD_SREF_EXIT, 16'h0000, t1);
        send(CMD_ACT, 16'h0000, t2);
        check(t2 - t1 >= SREF_NONREAD_CYC, 1);
        send(CMD_SREF_ENTER, 16'h0000, t0);
        send(CMD_SREF_EXIT, 16'h0000, t1);
        send(CMD_RD, 16'h0000, t2);
        check(t2 - t1 >= SREF_READ_CYC, 1);
    endtask : s_sref
    // Free-running clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Cycle count; a hung handshake ends the run here
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fails++;
            tally_and_finish();
        end
    end
    // Main sequence
    initial begin
        {arst_n, req_valid, req_odt, req_cmd, req_addr} = '0;
        {cyc, fails, checks_done} = '0;
        repeat (12) @(posedge clk);
        #1 arst_n = 1'b1;
        s_act_col();
        s_modes();
        s_power();
        s_sref();
        check(dev_errs, 8'h00);
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
